// ==== hdl/srp_pkg.sv ====
// constants and types for the synchronous rectifier gate logic
// assumes one 250 MHz core clock and a plain register port with 32-bit data
package srp_pkg;
   localparam int unsigned SRP_CLK_MHZ = 250;
   localparam int unsigned SRP_ADDR_W = 8;
   localparam int unsigned SRP_DATA_W = 32;
   localparam int unsigned SRP_CNT_W = 16;
   localparam int unsigned SRP_NUM_OUT = 8;

   localparam logic [7:0] SRP_CTRL_ADDR = 8'h00;
   localparam logic [7:0] SRP_CLAMP_ADDR = 8'h04;
   localparam logic [7:0] SRP_RISE_DLY_ADDR = 8'h08;
   localparam logic [7:0] SRP_FALL_DLY_ADDR = 8'h0c;
   localparam logic [7:0] SRP_STATUS_ADDR = 8'h10;

   localparam logic [7:0] SRP_CTRL_RESET = 8'h00;
   localparam logic [15:0] SRP_CLAMP_RESET = 16'h00ff;
   localparam logic [15:0] SRP_DLY_RESET = 16'h0000;

   // status word layout
   localparam int unsigned SRP_ST_STATE_A = 0;
   localparam int unsigned SRP_ST_STATE_B = 1;
   localparam int unsigned SRP_ST_ON = 2;
   localparam int unsigned SRP_ST_RUN = 3;
   localparam int unsigned SRP_ST_CNT_LSB = 16;

   // logic output positions
   localparam int unsigned SRP_OUT_A = 0;
   localparam int unsigned SRP_OUT_A_OE = 1;
   localparam int unsigned SRP_OUT_B = 2;
   localparam int unsigned SRP_OUT_B_OE = 3;
   localparam int unsigned SRP_OUT_QA0 = 4;
   localparam int unsigned SRP_OUT_QB0 = 5;
   localparam int unsigned SRP_OUT_QA1 = 6;
   localparam int unsigned SRP_OUT_QB1 = 7;

   // edge events, fall_a in bit 0 up to rise_a in bit 3
   typedef struct packed {
      logic rise_a;
      logic rise_b;
      logic fall_b;
      logic fall_a;
   } srp_events_t;

   typedef struct packed {
      logic [SRP_ADDR_W-1:0] addr;
      logic [SRP_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } srp_bus_req_t;
endpackage

// ==== hdl/srp_rect_logic.sv ====
// synchronous rectifier gate logic: edge events, clamp counter, two state bits,
// logic output mux and a two-channel turn-on delay stage
// assumes primary pwm pins and the on control are asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module srp_rect_logic
   import srp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic primary_out_a,
   input wire logic primary_out_b,
   input wire logic rectifier_on_control,
   input wire srp_bus_req_t bus_req,
   output logic [SRP_DATA_W-1:0] bus_rdata,
   output logic [SRP_NUM_OUT-1:0] logic_out,
   output logic rect_out_a,
   output logic rect_out_b
);
   // pin synchronisers, the third stage is the edge reference
   logic [2:0] pin_s1_reg, pin_s1_next;
   logic [2:0] pin_s2_reg, pin_s2_next;
   logic [2:0] pin_d_reg, pin_d_next;
   srp_events_t ev;
   logic on_ok;

   always_comb begin
      pin_s1_next = {rectifier_on_control, primary_out_b, primary_out_a};
      pin_s2_next = pin_s1_reg;
      pin_d_next = pin_s2_reg;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         pin_d_reg <= 3'h0;
      end else begin
         pin_s1_reg <= pin_s1_next;
         pin_s2_reg <= pin_s2_next;
         pin_d_reg <= pin_d_next;
      end
   end

   always_comb begin
      ev.fall_a = ~pin_s2_reg[0] & pin_d_reg[0];
      ev.fall_b = ~pin_s2_reg[1] & pin_d_reg[1];
      ev.rise_b = pin_s2_reg[1] & ~pin_d_reg[1];
      ev.rise_a = pin_s2_reg[0] & ~pin_d_reg[0];
      on_ok = pin_s2_reg[2];
   end

   // register file
   logic [7:0] ctrl_reg, ctrl_next;
   logic [15:0] clamp_reg, clamp_next;
   logic [15:0] rise_dly_reg, rise_dly_next;
   logic [15:0] fall_dly_reg, fall_dly_next;
   logic [SRP_DATA_W-1:0] rdata_reg, rdata_next;
   logic state_a_reg, state_b_reg, run_reg;
   logic [SRP_CNT_W-1:0] cnt_reg;

   always_comb begin
      ctrl_next = ctrl_reg;
      clamp_next = clamp_reg;
      rise_dly_next = rise_dly_reg;
      fall_dly_next = fall_dly_reg;
      rdata_next = '0;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            SRP_CTRL_ADDR: ctrl_next = bus_req.wdata[7:0];
            SRP_CLAMP_ADDR: clamp_next = bus_req.wdata[15:0];
            SRP_RISE_DLY_ADDR: rise_dly_next = bus_req.wdata[15:0];
            SRP_FALL_DLY_ADDR: fall_dly_next = bus_req.wdata[15:0];
            default: ;
         endcase
      end
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            SRP_CTRL_ADDR: rdata_next = {24'h000000, ctrl_reg};
            SRP_CLAMP_ADDR: rdata_next = {16'h0000, clamp_reg};
            SRP_RISE_DLY_ADDR: rdata_next = {16'h0000, rise_dly_reg};
            SRP_FALL_DLY_ADDR: rdata_next = {16'h0000, fall_dly_reg};
            SRP_STATUS_ADDR: begin
               rdata_next[SRP_ST_STATE_A] = state_a_reg;
               rdata_next[SRP_ST_STATE_B] = state_b_reg;
               rdata_next[SRP_ST_ON] = on_ok;
               rdata_next[SRP_ST_RUN] = run_reg;
               rdata_next[SRP_ST_CNT_LSB +: SRP_CNT_W] = cnt_reg;
            end
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_reg <= SRP_CTRL_RESET;
         clamp_reg <= SRP_CLAMP_RESET;
         rise_dly_reg <= SRP_DLY_RESET;
         fall_dly_reg <= SRP_DLY_RESET;
         rdata_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         clamp_reg <= clamp_next;
         rise_dly_reg <= rise_dly_next;
         fall_dly_reg <= fall_dly_next;
         rdata_reg <= rdata_next;
      end
   end

   assign bus_rdata = rdata_reg;

   // on-time counter and the two state bits
   logic run_next, state_a_next, state_b_next;
   logic [SRP_CNT_W-1:0] cnt_next;
   logic match, clear_a;

   always_comb begin
      // match fires when a running count reaches the clamp value
      match = run_reg & (cnt_reg == clamp_reg);
      run_next = run_reg;
      cnt_next = cnt_reg;
      if (ev.rise_a) begin
         run_next = 1'b1;
         cnt_next = '0;
      end else if (match) begin
         run_next = 1'b0;
      end else if (run_reg) begin
         cnt_next = cnt_reg + 16'h0001;
      end
      // whichever end comes first wins, so no mode select exists
      clear_a = ev.fall_a | match;
      state_a_next = (~state_a_reg & ev.rise_a) | (state_a_reg & ~clear_a);
      // first event is the fall of primary b, second event its rise
      state_b_next = (state_b_reg & ~ev.rise_b) | (~state_b_reg & ev.fall_b);
      if (!on_ok) begin
         state_a_next = 1'b0;
         state_b_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         run_reg <= 1'b0;
         cnt_reg <= '0;
         state_a_reg <= 1'b0;
         state_b_reg <= 1'b0;
      end else begin
         run_reg <= run_next;
         cnt_reg <= cnt_next;
         state_a_reg <= state_a_next;
         state_b_reg <= state_b_next;
      end
   end

   // turn-on delay stage fed by the qualifier signals
   logic [15:0] dly_a_reg, dly_a_next, dly_b_reg, dly_b_next;
   logic db_a_reg, db_a_next, db_b_inv_reg, db_b_inv_next;
   logic b_inv;

   always_comb begin
      // channel a: rising-edge delay on the qualifier itself
      db_a_next = 1'b0;
      dly_a_next = '0;
      if (state_a_reg) begin
         db_a_next = db_a_reg;
         dly_a_next = dly_a_reg;
         if (!db_a_reg) begin
            if (dly_a_reg == rise_dly_reg) begin
               db_a_next = 1'b1;
            end else begin
               dly_a_next = dly_a_reg + 16'h0001;
            end
         end
      end
      // channel b: invert, delay the falling edge, invert back
      b_inv = ~state_b_reg;
      db_b_inv_next = 1'b1;
      dly_b_next = '0;
      if (!b_inv) begin
         db_b_inv_next = db_b_inv_reg;
         dly_b_next = dly_b_reg;
         if (db_b_inv_reg) begin
            if (dly_b_reg == fall_dly_reg) begin
               db_b_inv_next = 1'b0;
            end else begin
               dly_b_next = dly_b_reg + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         db_a_reg <= 1'b0;
         db_b_inv_reg <= 1'b1;
         dly_a_reg <= '0;
         dly_b_reg <= '0;
      end else begin
         db_a_reg <= db_a_next;
         db_b_inv_reg <= db_b_inv_next;
         dly_a_reg <= dly_a_next;
         dly_b_reg <= dly_b_next;
      end
   end

   // logic output mux, each bit gated by its own bit of ctrl_reg
   logic [SRP_NUM_OUT-1:0] out_raw, out_reg, out_next;
   logic ra_reg, ra_next, rb_reg, rb_next;

   always_comb begin
      out_raw[SRP_OUT_A] = db_a_reg;
      out_raw[SRP_OUT_A_OE] = on_ok;
      out_raw[SRP_OUT_B] = ~db_b_inv_reg;
      out_raw[SRP_OUT_B_OE] = on_ok;
      out_raw[SRP_OUT_QA0] = state_a_reg;
      out_raw[SRP_OUT_QB0] = state_b_reg;
      out_raw[SRP_OUT_QA1] = state_a_reg;
      out_raw[SRP_OUT_QB1] = state_b_reg;
      out_next = out_raw & ctrl_reg;
      ra_next = db_a_reg;
      rb_next = ~db_b_inv_reg;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         out_reg <= '0;
         ra_reg <= 1'b0;
         rb_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
         ra_reg <= ra_next;
         rb_reg <= rb_next;
      end
   end

   assign logic_out = out_reg;
   assign rect_out_a = ra_reg;
   assign rect_out_b = rb_reg;
endmodule
`default_nettype wire

// ==== verification/srp_primary_model.sv ====
// primary-side pwm model: complementary a and b with fixed dead time
// assumes the bench sets the high length only while stopped
`timescale 1ns/1ps
`default_nettype none
module srp_primary_model (
   input wire logic core_clk,
   input wire logic run,
   input wire logic [15:0] high_len,
   output logic primary_out_a,
   output logic primary_out_b
);
   localparam int DEAD = 4;
   int cnt;
   // dead time keeps pin edges at least four cycles apart
   always_ff @(posedge core_clk) begin
      if (!run) begin
         cnt <= 0;
         primary_out_a <= 1'b0;
         primary_out_b <= 1'b0;
      end else begin
         cnt <= (cnt >= 2 * (high_len + DEAD) - 1) ? 0 : cnt + 1;
         primary_out_a <= cnt < high_len;
         primary_out_b <= cnt >= high_len + DEAD && cnt < 2 * high_len + DEAD;
      end
   end
endmodule
`default_nettype wire

// ==== verification/srp_rect_logic_bench.sv ====
// self-checking bench for the rectifier gate logic
// assumes the primary pwm model on the pins and the bound checker
`timescale 1ns/1ps
`default_nettype none
module srp_rect_logic_bench
   import srp_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst;
   logic run;
   logic rectifier_on_control;
   logic [15:0] high_len;
   srp_bus_req_t bus_req;
   wire logic primary_out_a, primary_out_b, rect_out_a, rect_out_b;
   wire logic [31:0] bus_rdata;
   wire logic [7:0] logic_out;
   wire logic [3:0] probe = {rect_out_b, rect_out_a, logic_out[5], logic_out[4]};
   int n_mismatch = 0;
   int n_checks = 0;
   int n;
   logic [9:0] acc;
   always #2 core_clk = ~core_clk;
   srp_primary_model model (.core_clk, .run, .high_len, .primary_out_a, .primary_out_b);
   srp_rect_logic dut (.core_clk, .rst, .primary_out_a, .primary_out_b, .rectifier_on_control,
      .bus_req, .bus_rdata, .logic_out, .rect_out_a, .rect_out_b);
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      bus_req <= {a, v, 1'b1, 1'b0};
      @(posedge core_clk);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      bus_req <= {a, 32'h0, 1'b0, 1'b1};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
      check(bus_rdata, exp);
   endtask
   task automatic go(input logic r, input logic on);
      @(posedge core_clk);
      run <= r;
      rectifier_on_control <= on;
   endtask
   // length of the next high pulse on one probe bit
   task automatic measure(input int sel, output int len);
      int t;
      t = 0;
      len = 0;
      while (probe[sel] !== 1'b0 && t < 500) begin
         tick();
         t++;
      end
      while (probe[sel] !== 1'b1 && t < 500) begin
         tick();
         t++;
      end
      while (probe[sel] === 1'b1 && t < 500) begin
         tick();
         t++;
         len++;
      end
   endtask
   task automatic gather(output logic [9:0] a);
      a = '0;
      repeat (60) begin
         tick();
         a = a | {rect_out_b, rect_out_a, logic_out};
      end
   endtask
   task automatic conclude;
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      run = 1'b0;
      rectifier_on_control = 1'b1;
      high_len = 16'h0014;
      bus_req = '0;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      rd(SRP_CTRL_ADDR, {24'h0, SRP_CTRL_RESET});
      rd(SRP_CLAMP_ADDR, 32'h0000_00ff);
      rd(SRP_RISE_DLY_ADDR, 32'h0);
      rd(SRP_FALL_DLY_ADDR, 32'h0);
      // idle pins: only the synchronised on control shows in the status word
      rd(SRP_STATUS_ADDR, 32'h0000_0001 << SRP_ST_ON);
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, 32'h0);
      wr(SRP_CTRL_ADDR, 32'hff);
      rd(SRP_CTRL_ADDR, 32'hff);
      go(1'b1, 1'b1);
      measure(0, n);
      check(n, 32'h14);
      measure(1, n);
      check(n, 32'h1c);
      // zero rise delay leaves the pulse length unchanged
      measure(2, n);
      check(n, 32'h14);
      go(1'b0, 1'b1);
      wr(SRP_RISE_DLY_ADDR, 32'h3);
      wr(SRP_FALL_DLY_ADDR, 32'h2);
      go(1'b1, 1'b1);
      // a turn-on delay of d cycles shortens the pulse by d
      measure(2, n);
      check(n, 32'h11);
      measure(3, n);
      check(n, 32'h1a);
      go(1'b0, 1'b1);
      wr(SRP_CLAMP_ADDR, 32'h5);
      go(1'b1, 1'b1);
      measure(0, n);
      check(n, 32'h6);
      measure(2, n);
      check(n, 32'h3);
      wr(SRP_CTRL_ADDR, 32'h0f);
      gather(acc);
      check(acc[7:4], 4'h0);
      check({acc[3], acc[1]}, 2'b11);
      wr(SRP_CTRL_ADDR, 32'hff);
      go(1'b1, 1'b0);
      repeat (8) tick();
      gather(acc);
      check(acc, 10'h000);
      go(1'b1, 1'b1);
      measure(0, n);
      check(n, 32'h6);
      conclude();
   end
endmodule
`default_nettype wire

// ==== verification/srp_rect_logic_props.sv ====
// port-level assertions for the rectifier gate logic
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module srp_rect_logic_props
   import srp_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic primary_out_a,
   input wire logic primary_out_b,
   input wire logic rectifier_on_control,
   input wire srp_bus_req_t bus_req,
   input wire logic [SRP_DATA_W-1:0] bus_rdata,
   input wire logic [SRP_NUM_OUT-1:0] logic_out,
   input wire logic rect_out_a,
   input wire logic rect_out_b
);
   logic [7:0] ctrl_seen;
   logic [15:0] clamp_seen;
   logic [15:0] hi_cnt;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // shadow of ctrl and clamp, and the running length of qualifier A
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_seen <= SRP_CTRL_RESET;
         clamp_seen <= SRP_CLAMP_RESET;
         hi_cnt <= '0;
      end else begin
         if (bus_req.wr && bus_req.addr == SRP_CTRL_ADDR) ctrl_seen <= bus_req.wdata[7:0];
         if (bus_req.wr && bus_req.addr == SRP_CLAMP_ADDR) clamp_seen <= bus_req.wdata[15:0];
         hi_cnt <= logic_out[4] ? hi_cnt + 16'h0001 : 16'h0000;
      end
   end
   a_reset_quiet: assert property (
      $past(rst) |-> logic_out == '0 && !rect_out_a && !rect_out_b)
      else $error("outputs not clear after reset");
   a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == '0)
      else $error("read data outside its cycle");
   a_a_sets: assert property (
      $rose(primary_out_a) && ctrl_seen[4] && $past(rectifier_on_control, 4)
      && rectifier_on_control |-> ##[3:5] logic_out[4])
      else $error("qualifier a did not follow primary rise");
   a_a_clears: assert property ($fell(primary_out_a) |-> ##[3:5] !logic_out[4])
      else $error("qualifier a did not drop on primary fall");
   a_clamp_len: assert property (
      logic_out[4] |-> {1'b0, hi_cnt} < {1'b0, clamp_seen} + 17'h00001)
      else $error("qualifier a longer than clamp");
   a_b_sets: assert property (
      $fell(primary_out_b) && ctrl_seen[5] && $past(rectifier_on_control, 4)
      && rectifier_on_control |-> ##[3:5] logic_out[5])
      else $error("qualifier b did not rise on primary fall");
   a_b_clears: assert property ($rose(primary_out_b) |-> ##[3:5] !logic_out[5])
      else $error("qualifier b did not drop on primary rise");
   a_off_quiet: assert property (
      !rectifier_on_control [*7] |-> logic_out[7:4] == 4'h0 && !rect_out_a && !rect_out_b)
      else $error("outputs active while off");
   a_out_mirror: assert property (
      $stable(ctrl_seen) && ctrl_seen[7:4] == 4'hf |-> logic_out[7:6] == logic_out[5:4])
      else $error("qualifier copies differ");
   // logic_out lags the enable by one cycle, so the enable must stand on both samples
   a_rect_follows: assert property (
      $rose(rect_out_a) && ctrl_seen[4] && $past(ctrl_seen[4]) |-> logic_out[4])
      else $error("rectifier a rose without its state");
endmodule
bind srp_rect_logic srp_rect_logic_props u_props (.core_clk, .rst, .primary_out_a,
   .primary_out_b, .rectifier_on_control, .bus_req, .bus_rdata, .logic_out, .rect_out_a,
   .rect_out_b);
`default_nettype wire
